// ### core/sclg_top.sv
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module sclg_top #(
    parameter int unsigned STRAP_CYC = sclg_pkg::SCLG_STRAP_CYCLES,
    parameter int unsigned MEM_COPIES = 16,
    parameter int unsigned BUS_COPIES = 5
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic supply_good_i,
    input wire logic ref_clk_lvl_i,
    input wire logic clk24_lvl_i,
    input wire logic clk48_lvl_i,
    input wire logic bus_clk_lvl_i,
    input wire logic memory_clock_in_i,
    input wire logic clk_stop_n_i,
    input wire logic freq_select_bit_a_i,
    output logic freq_select_bit_a_o,
    output logic freq_select_bit_a_oe_n_o,
    input wire logic freq_select_bit_b_i,
    output logic freq_select_bit_b_o,
    output logic freq_select_bit_b_oe_n_o,
    input wire logic freq_select_bit_c_i,
    output logic freq_select_bit_c_o,
    output logic freq_select_bit_c_oe_n_o,
    input wire logic freq_select_bit_d_i,
    output logic freq_select_bit_d_o,
    output logic freq_select_bit_d_oe_n_o,
    input wire logic mode_strap_i,
    output logic mode_strap_o,
    output logic mode_strap_oe_n_o,
    input wire logic reference_out_a_i,
    output logic reference_out_a_o,
    output logic reference_out_a_oe_n_o,
    output logic [BUS_COPIES-1:0] stoppable_bus_clocks_o,
    output logic [MEM_COPIES-1:0] gated_memory_clocks_o,
    output logic free_memory_clock_o,
    input wire logic [sclg_pkg::SCLG_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    import sclg_pkg::*;

    sclg_state_t state_q;
    logic [SCLG_CNT_W-1:0] cnt_q;
    logic [4:0] straps_q;
    logic [4:0] pin_sample;
    logic run_q;
    logic [1:0] ctrl_q;
    logic bus_prev_q, bus_smp_q, bus_en_q;
    logic mem_prev_q, mem_smp_q, mem_en_q;
    logic bus_stop_req, bus_rise, bus_fall, mem_rise, mem_fall;
    logic req, wait_q;

    localparam logic [SCLG_CNT_W-1:0] CNT_LAST = SCLG_CNT_W'(STRAP_CYC - 1);

    assign pin_sample = {mode_strap_i, freq_select_bit_d_i, freq_select_bit_c_i,
                         freq_select_bit_b_i, freq_select_bit_a_i};

    // Power-up sequencer
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= SCLG_ST_POWER;
            cnt_q <= '0;
            run_q <= 1'b0;
        end else begin
            unique case (state_q)
                SCLG_ST_POWER: begin
                    cnt_q <= '0;
                    if (supply_good_i) begin
                        state_q <= SCLG_ST_SAMPLE;
                    end
                end
                SCLG_ST_SAMPLE: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_LAST) begin
                        state_q <= SCLG_ST_LATCH;
                    end
                end
                SCLG_ST_LATCH: begin
                    state_q <= SCLG_ST_RUN;
                    run_q <= 1'b1;
                end
                SCLG_ST_RUN: begin
                    state_q <= SCLG_ST_RUN;
                end
            endcase
        end
    end

    // Straps are written only in the latch state; power-on reset alone clears them
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            straps_q <= SCLG_STRAP_RST;
        end else if (state_q == SCLG_ST_LATCH) begin
            straps_q <= pin_sample;
        end
    end

    // Mode strap 0 turns the shared pin into the active-low bus stop input
    always_comb begin
        bus_stop_req = 1'b0;
        if (run_q && !straps_q[SCLG_STRAP_MODE]) begin
            bus_stop_req = !reference_out_a_i;
        end
        if (ctrl_q[SCLG_CTRL_BUS_STOP_BIT]) begin
            bus_stop_req = 1'b1;
        end
    end

    assign bus_rise = bus_clk_lvl_i && !bus_prev_q;
    assign bus_fall = !bus_clk_lvl_i && bus_prev_q;
    assign mem_rise = memory_clock_in_i && !mem_prev_q;
    assign mem_fall = !memory_clock_in_i && mem_prev_q;

    // Bus stop: sample on rise, switch the gate in the following low phase
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            bus_prev_q <= 1'b0;
            bus_smp_q <= 1'b1;
            bus_en_q <= 1'b1;
        end else begin
            bus_prev_q <= bus_clk_lvl_i;
            if (bus_rise) begin
                bus_smp_q <= !bus_stop_req;
            end
            if (bus_fall) begin
                bus_en_q <= bus_smp_q;
            end
        end
    end

    // Global stop: memory gate changes only in a low phase, full cycles kept
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mem_prev_q <= 1'b0;
            mem_smp_q <= 1'b1;
            mem_en_q <= 1'b1;
        end else begin
            mem_prev_q <= memory_clock_in_i;
            if (mem_rise) begin
                mem_smp_q <= clk_stop_n_i && !ctrl_q[SCLG_CTRL_MEM_STOP_BIT];
            end
            if (mem_fall) begin
                mem_en_q <= mem_smp_q;
            end
        end
    end

    // Clock fanout
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            stoppable_bus_clocks_o <= '0;
            gated_memory_clocks_o <= '0;
            free_memory_clock_o <= 1'b0;
        end else begin
            stoppable_bus_clocks_o <= {BUS_COPIES{bus_clk_lvl_i && bus_en_q}};
            gated_memory_clocks_o <= {MEM_COPIES{memory_clock_in_i && mem_en_q}};
            free_memory_clock_o <= memory_clock_in_i;
        end
    end

    // Dual-purpose pins: three-stated until the straps are latched
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !run_q) begin
            freq_select_bit_a_o <= 1'b0;
            freq_select_bit_b_o <= 1'b0;
            freq_select_bit_c_o <= 1'b0;
            freq_select_bit_d_o <= 1'b0;
            mode_strap_o <= 1'b0;
            freq_select_bit_a_oe_n_o <= 1'b1;
            freq_select_bit_b_oe_n_o <= 1'b1;
            freq_select_bit_c_oe_n_o <= 1'b1;
            freq_select_bit_d_oe_n_o <= 1'b1;
            mode_strap_oe_n_o <= 1'b1;
        end else begin
            freq_select_bit_a_o <= clk24_lvl_i;
            freq_select_bit_b_o <= clk48_lvl_i;
            freq_select_bit_c_o <= ref_clk_lvl_i;
            freq_select_bit_d_o <= bus_clk_lvl_i && bus_en_q;
            mode_strap_o <= bus_clk_lvl_i;
            freq_select_bit_a_oe_n_o <= 1'b0;
            freq_select_bit_b_oe_n_o <= 1'b0;
            freq_select_bit_c_oe_n_o <= 1'b0;
            freq_select_bit_d_oe_n_o <= 1'b0;
            mode_strap_oe_n_o <= 1'b0;
        end
    end

    // Shared reference/stop pin
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !run_q || !straps_q[SCLG_STRAP_MODE]) begin
            reference_out_a_o <= 1'b0;
            reference_out_a_oe_n_o <= 1'b1;
        end else begin
            reference_out_a_o <= ref_clk_lvl_i;
            reference_out_a_oe_n_o <= 1'b0;
        end
    end

    // Avalon slave: one wait cycle per access
    assign req = avs_read_i || avs_write_i;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(req && wait_q);
        end
    end

    assign avs_waitrequest_o = wait_q;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_q <= SCLG_CTRL_RST;
        end else if (avs_write_i && !wait_q && avs_address_i == SCLG_CTRL_OFS) begin
            ctrl_q <= avs_writedata_i[1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && wait_q) begin
            avs_readdata_o <= '0;
            if (avs_address_i == SCLG_CTRL_OFS) begin
                avs_readdata_o[1:0] <= ctrl_q;
            end else if (avs_address_i == SCLG_STAT_OFS) begin
                avs_readdata_o[SCLG_STAT_FS_LSB +: 4] <= straps_q[3:0];
                avs_readdata_o[SCLG_STAT_MODE_BIT] <= straps_q[SCLG_STRAP_MODE];
                avs_readdata_o[SCLG_STAT_RUN_BIT] <= run_q;
                avs_readdata_o[SCLG_STAT_BUS_RUN_BIT] <= bus_en_q;
                avs_readdata_o[SCLG_STAT_MEM_RUN_BIT] <= mem_en_q;
            end
        end
    end

    // Checks
    sequence latch_step_s;
        state_q == SCLG_ST_LATCH;
    endsequence

    sequence enable_step_s;
        run_q && straps_q == $past(pin_sample);
    endsequence

    chk_pins_three_stated: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !run_q |=> (freq_select_bit_a_oe_n_o && freq_select_bit_d_oe_n_o && mode_strap_oe_n_o))
        else $error("dual pin driven before straps latched");

    chk_latch_then_enable: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        latch_step_s |=> enable_step_s ##1 !freq_select_bit_b_oe_n_o)
        else $error("strap latch or output enable out of order");

    chk_straps_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_q |=> $stable(straps_q))
        else $error("latched straps changed");

    chk_timer_waits_supply: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_q == SCLG_ST_POWER && !supply_good_i) |=> state_q == SCLG_ST_POWER && cnt_q == '0)
        else $error("strap timer started without supply");

    chk_bus_gate_low: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $changed(bus_en_q) |-> !$past(bus_clk_lvl_i))
        else $error("bus gate switched while clock high");

    chk_bus_stopped_low: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !bus_en_q |=> stoppable_bus_clocks_o == '0)
        else $error("stopped bus clock not low");

    chk_mem_gated_low: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !mem_en_q |=> gated_memory_clocks_o == '0)
        else $error("stopped memory clock not low");

    chk_mem_free_copy: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> free_memory_clock_o == $past(memory_clock_in_i))
        else $error("free memory clock not a copy");

    chk_shared_ref_out: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (run_q && straps_q[SCLG_STRAP_MODE]) |=>
            (!reference_out_a_oe_n_o && reference_out_a_o == $past(ref_clk_lvl_i)))
        else $error("shared pin not driving reference");

    chk_bus_one_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (req && wait_q) |=> !wait_q ##1 wait_q)
        else $error("bus answer timing wrong");

endmodule : sclg_top

// ### include/sclg_pkg.sv
package sclg_pkg;

    // Timing
    localparam int unsigned SCLG_CLK_PERIOD_NS = 4;
    localparam int unsigned SCLG_STRAP_TIME_MS = 2;
    localparam int unsigned SCLG_NS_PER_MS = 1000000;
    localparam int unsigned SCLG_STRAP_CYCLES =
        (SCLG_STRAP_TIME_MS * SCLG_NS_PER_MS + SCLG_CLK_PERIOD_NS - 1) / SCLG_CLK_PERIOD_NS;
    localparam int unsigned SCLG_CNT_W = 20;

    // Register map, byte addresses
    localparam int unsigned SCLG_ADDR_W = 4;
    localparam logic [3:0] SCLG_CTRL_OFS = 4'h0;
    localparam logic [3:0] SCLG_STAT_OFS = 4'h4;

    // Control fields
    localparam int unsigned SCLG_CTRL_BUS_STOP_BIT = 0;
    localparam int unsigned SCLG_CTRL_MEM_STOP_BIT = 1;
    localparam logic [1:0] SCLG_CTRL_RST = 2'h0;

    // Status fields
    localparam int unsigned SCLG_STAT_FS_LSB = 0;
    localparam int unsigned SCLG_STAT_MODE_BIT = 4;
    localparam int unsigned SCLG_STAT_RUN_BIT = 5;
    localparam int unsigned SCLG_STAT_BUS_RUN_BIT = 6;
    localparam int unsigned SCLG_STAT_MEM_RUN_BIT = 7;

    // Strap vector positions
    localparam int unsigned SCLG_STRAP_A = 0;
    localparam int unsigned SCLG_STRAP_B = 1;
    localparam int unsigned SCLG_STRAP_C = 2;
    localparam int unsigned SCLG_STRAP_D = 3;
    localparam int unsigned SCLG_STRAP_MODE = 4;
    localparam logic [4:0] SCLG_STRAP_RST = 5'h00;

    typedef enum logic [3:0] {
        SCLG_ST_POWER  = 4'h1,
        SCLG_ST_SAMPLE = 4'h2,
        SCLG_ST_LATCH  = 4'h4,
        SCLG_ST_RUN    = 4'h8
    } sclg_state_t;

endpackage : sclg_pkg

// ### dv/sclg_board.sv
`timescale 1ns/1ps
module sclg_board (
    input wire logic [5:0] pin_o_i,
    input wire logic [5:0] pin_oe_n_i,
    input wire logic [4:0] strap_i,
    input wire logic bus_stop_n_i,
    output logic [5:0] pin_i_o
);
    logic [5:0] pull;
    // Released pins fall to the strap resistor or the chipset stop level
    assign pull = {bus_stop_n_i, strap_i};
    assign pin_i_o = (pin_oe_n_i & pull) | (~pin_oe_n_i & pin_o_i);
endmodule : sclg_board

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sclg_pkg::*;
    localparam int unsigned STRAP = 20;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic supply_good_i = 1'b0;
    logic ref_clk_lvl_i = 1'b0;
    logic clk24_lvl_i = 1'b0;
    logic clk48_lvl_i = 1'b0;
    logic bus_clk_lvl_i = 1'b0;
    logic memory_clock_in_i = 1'b0;
    logic clk_stop_n_i = 1'b1;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [5:0] pin_o, pin_oe_n, pin_i;
    logic [4:0] strap = 5'h00;
    logic [4:0] saved;
    logic bus_stop_n = 1'b1;
    logic [4:0] bus_clks;
    logic [15:0] mem_clks;
    logic free_mem;
    logic [7:0] cnt = 8'h00;
    logic [31:0] rd;
    int errors = 0, tests_run = 0, cycles = 0, seed = 32'h1189, k, b_hi, m_hi, bad;

    sclg_top #(.STRAP_CYC(STRAP)) u_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .supply_good_i(supply_good_i),
        .ref_clk_lvl_i(ref_clk_lvl_i), .clk24_lvl_i(clk24_lvl_i), .clk48_lvl_i(clk48_lvl_i),
        .bus_clk_lvl_i(bus_clk_lvl_i), .memory_clock_in_i(memory_clock_in_i),
        .clk_stop_n_i(clk_stop_n_i),
        .freq_select_bit_a_i(pin_i[0]), .freq_select_bit_a_o(pin_o[0]),
        .freq_select_bit_a_oe_n_o(pin_oe_n[0]),
        .freq_select_bit_b_i(pin_i[1]), .freq_select_bit_b_o(pin_o[1]),
        .freq_select_bit_b_oe_n_o(pin_oe_n[1]),
        .freq_select_bit_c_i(pin_i[2]), .freq_select_bit_c_o(pin_o[2]),
        .freq_select_bit_c_oe_n_o(pin_oe_n[2]),
        .freq_select_bit_d_i(pin_i[3]), .freq_select_bit_d_o(pin_o[3]),
        .freq_select_bit_d_oe_n_o(pin_oe_n[3]),
        .mode_strap_i(pin_i[4]), .mode_strap_o(pin_o[4]), .mode_strap_oe_n_o(pin_oe_n[4]),
        .reference_out_a_i(pin_i[5]), .reference_out_a_o(pin_o[5]),
        .reference_out_a_oe_n_o(pin_oe_n[5]),
        .stoppable_bus_clocks_o(bus_clks), .gated_memory_clocks_o(mem_clks),
        .free_memory_clock_o(free_mem), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o)
    );

    sclg_board u_board (
        .pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n), .strap_i(strap),
        .bus_stop_n_i(bus_stop_n), .pin_i_o(pin_i)
    );

    always #2 clock_i = ~clock_i;

    // Slow clock levels seen as data
    always @(posedge clock_i) begin
        cnt <= cnt + 8'h01;
        clk24_lvl_i <= cnt[0];
        clk48_lvl_i <= ~cnt[0];
        memory_clock_in_i <= cnt[1];
        bus_clk_lvl_i <= cnt[2];
        ref_clk_lvl_i <= cnt[3];
        cycles <= cycles + 1;
        if (cycles > 6000) begin
            errors = errors + 1;
            complete_run();
        end
    end

    function automatic logic [31:0] exp_status(input logic [4:0] s, input logic bo, mo);
        return {24'h0, mo, bo, 1'b1, s};
    endfunction : exp_status

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                            output logic [31:0] d);
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        @(posedge clock_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
        d = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus_xfer

    task automatic span(output int bh, mh, bd);
        logic pm, pr;
        logic [2:0] pv;
        bh = 0;
        mh = 0;
        bd = 0;
        @(negedge clock_i);
        pm = memory_clock_in_i;
        pr = ref_clk_lvl_i;
        pv = {bus_clk_lvl_i, clk48_lvl_i, clk24_lvl_i};
        repeat (40) begin
            @(negedge clock_i);
            if (bus_clks !== 5'h00 || pin_o[3] !== 1'b0) bh++;
            if (mem_clks !== 16'h0) mh++;
            if (free_mem !== pm || (mem_clks !== 16'h0 && mem_clks !== {16{free_mem}})) bd++;
            if (pin_oe_n[5] === 1'b0 && pin_o[5] !== pr) bd++;
            // Dual pins copy their clock levels once running
            if (pin_o[2:0] !== {pr, pv[1:0]} || pin_o[4] !== pv[2]) bd++;
            if (bus_clks !== 5'h00 && (bus_clks !== {5{pv[2]}} || pin_o[3] !== pv[2])) bd++;
            pm = memory_clock_in_i;
            pr = ref_clk_lvl_i;
            pv = {bus_clk_lvl_i, clk48_lvl_i, clk24_lvl_i};
        end
    endtask : span

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    initial begin
        for (int m = 0; m < 2; m++) begin
            @(posedge clock_i);
            rst_n_i <= 1'b0;
            supply_good_i <= 1'b0;
            clk_stop_n_i <= 1'b1;
            bus_stop_n <= 1'b1;
            // Mode strap 0 on the first power cycle, 1 on the second
            strap <= {m[0], 4'($random(seed))};
            repeat (3) @(posedge clock_i);
            rst_n_i <= 1'b1;
            repeat (STRAP + 4) @(posedge clock_i);
            @(negedge clock_i) check(32'(pin_oe_n), 32'h3f);
            @(posedge clock_i) supply_good_i <= 1'b1;
            repeat (STRAP) @(posedge clock_i);
            @(negedge clock_i) check(32'(pin_oe_n), 32'h3f);
            k = 0;
            while (pin_oe_n[0] !== 1'b0 && k < 10) begin
                @(negedge clock_i);
                k++;
            end
            saved = strap;
            check(32'(pin_oe_n), 32'({~saved[4], 5'h00}));
            bus_xfer(1'b0, SCLG_STAT_OFS, 32'h0, rd);
            check(rd, exp_status(saved, 1'b1, 1'b1));
            strap <= ~saved;
            bus_xfer(1'b0, 4'h8, 32'h0, rd);
            check(rd, 32'h0);
            for (int v = 0; v < 6; v++) begin
                bus_xfer(1'b1, SCLG_CTRL_OFS, 32'(v[1:0]), rd);
                bus_stop_n <= ~v[2];
                clk_stop_n_i <= ~(v == 5);
                repeat (24) @(posedge clock_i);
                span(b_hi, m_hi, bad);
                check(32'(b_hi != 0), 32'(!(v[0] || (v[2] && !saved[4]))));
                check(32'(m_hi != 0), 32'(!(v[1] || v == 5)));
                check(32'(bad), 32'h0);
                bus_xfer(1'b0, SCLG_STAT_OFS, 32'h0, rd);
                check(rd, exp_status(saved, !(v[0] || (v[2] && !saved[4])),
                      !(v[1] || v == 5)));
            end
            $display("Power cycle %0d done", m);
        end
        complete_run();
    end
endmodule : tb_top
